// *** rtl/aspcc_pkg.sv ***
package aspcc_pkg;
    localparam logic [5:0]  ADDR_STATUS       = 6'h00;
    localparam logic [5:0]  ADDR_ADCMODE      = 6'h01;
    localparam logic [5:0]  ADDR_IFMODE       = 6'h02;
    localparam logic [5:0]  ADDR_DATA         = 6'h04;
    localparam logic [5:0]  ADDR_OFFSET       = 6'h30;
    localparam logic [5:0]  ADDR_GAIN         = 6'h38;
    localparam logic [7:0]  CMD_CONT_READ     = 8'h44;
    localparam logic [23:0] MID_SCALE         = 24'h800000;
    localparam logic [45:0] GAIN_NUM          = 46'h200000000000;
    localparam int          GAIN_SHIFT        = 22;
    localparam int          WEIGHT_SHIFT      = 16;
    localparam logic [16:0] W_VOLT            = 17'h01333;
    localparam logic [16:0] W_LOW             = 17'h0c000;
    localparam logic [7:0]  CRC_POLY          = 8'h07;
    localparam logic [1:0]  CRC_OFF           = 2'h0;
    localparam logic [1:0]  CRC_XOR           = 2'h1;
    localparam logic [5:0]  LEN_8             = 6'h08;
    localparam logic [5:0]  LEN_16            = 6'h10;
    localparam logic [5:0]  LEN_24            = 6'h18;
    localparam logic [5:0]  LEN_32            = 6'h20;
    localparam logic [5:0]  BYTE_LAST         = 6'h07;
    localparam int          SERIAL_RESET_CLKS = 64;
    localparam logic [6:0]  SRST_LAST         = 7'(SERIAL_RESET_CLKS - 1);
    localparam logic [2:0]  MODE_CONT         = 3'h0;
    localparam logic [2:0]  MODE_SINGLE       = 3'h1;
    localparam logic [2:0]  MODE_STANDBY      = 3'h2;
    localparam logic [2:0]  MODE_INT_ZERO     = 3'h4;
    localparam logic [2:0]  MODE_INT_FULL     = 3'h5;
    localparam logic [2:0]  MODE_SYS_ZERO     = 3'h6;
    localparam logic [2:0]  MODE_SYS_FULL     = 3'h7;
    localparam logic [1:0]  ROUTE_NORMAL      = 2'h0;
    localparam logic [1:0]  ROUTE_SHORT       = 2'h1;
    localparam logic [1:0]  ROUTE_FULL        = 2'h2;
    localparam logic [15:0] ADCMODE_RESET     = 16'h0000;
    localparam logic [15:0] IFMODE_RESET      = 16'h0000;

    typedef enum logic [3:0] {
        ST_CMD  = 4'b0001,
        ST_WR   = 4'b0010,
        ST_WCRC = 4'b0100,
        ST_RD   = 4'b1000
    } aspcc_state_t;

    typedef struct packed {
        logic [8:0] rsvd_hi;
        logic [2:0] mode;
        logic [3:0] rsvd_lo;
    } aspcc_adcmode_t;

    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic       cont_read;
        logic       data_stat;
        logic [1:0] rsvd_mid;
        logic [1:0] crc_sel;
        logic [1:0] rsvd_lo;
    } aspcc_ifmode_t;

    typedef struct packed {
        logic       rdy_n;
        logic       adc_err;
        logic       crc_err;
        logic       rsvd;
        logic [3:0] channel;
    } aspcc_status_t;
endpackage : aspcc_pkg

// *** rtl/aspcc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - Four calibration modes from mode field
// - Results corrected by offset and gain
// - Offset resets mid-scale, gain factory value
// - Unipolar: corrected value times two
// - Bipolar: corrected value plus mid-scale
// - Input ratio weighted 0.075 or 0.75
// - Calibration write raises ready immediately
// - Calibration end updates coefficient, ready, standby
// - Internal calibrations reroute converter input
// - Calibration lasts one normal conversion
// - Coefficients locked during internal calibration
// - Data line low on result, high after read
// - Ready rises before data register updates
// - Repeated reads allowed, continuous read once
// - Works with chip select tied low
// - Sixty-four ones reset interface and registers
// - Bad write checksum blocks commit, flags error
// - Writes polynomial checksum; reads selectable
// - Checksum byte ends every transaction
// - Continuous read checksum includes implied command
// - Polynomial checksum x^8+x^2+x+1 remainder
// - XOR checksum over all transaction bytes
// - Status byte appended to data reads
module aspcc_top #(
    // Factory gain trim stand-in; value is arbitrary
    parameter logic [23:0] GAIN_RESET = 24'h555550
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               sclk,
    input  wire logic               cs_n,
    input  wire logic               din,
    output logic                    dout,
    output logic                    dout_oe,
    input  wire logic               conv_valid,
    input  wire logic signed [23:0] conv_ratio,
    input  wire logic [3:0]         conv_channel,
    input  wire logic               low_level_input,
    input  wire logic               bipolar_coding,
    output logic [1:0]              cal_route,
    output logic                    conv_enable
);
    aspcc_pkg::aspcc_state_t   st_r;
    aspcc_pkg::aspcc_adcmode_t adcmode_r;
    aspcc_pkg::aspcc_ifmode_t  ifmode_r;
    aspcc_pkg::aspcc_status_t  stat;
    logic [2:0]         sync_a_r;
    logic [2:0]         sync_b_r;
    logic               sclk_d_r;
    logic [5:0]         bit_cnt_r;
    logic [5:0]         len_r;
    logic [5:0]         addr_r;
    logic [31:0]        rx_sr_r;
    logic [31:0]        tx_sr_r;
    logic [23:0]        wdata_r;
    logic [7:0]         crc_r;
    logic [7:0]         xacc_r;
    logic               data_rd_r;
    logic [6:0]         ones_cnt_r;
    logic [23:0]        offset_r;
    logic [23:0]        gain_r;
    logic [23:0]        data_r;
    logic [3:0]         chan_r;
    logic               rdy_n_r;
    logic               crc_err_r;
    logic               stage_r;
    logic               cont_pend_r;
    logic signed [24:0] samp_r;

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        crc_step = {c[6:0], 1'b0} ^ (fb ? aspcc_pkg::CRC_POLY : 8'h00);
    endfunction : crc_step

    function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] acc;
        acc = c;
        for (int i = 7; i >= 0; i--) begin
            acc = crc_step(acc, b[i]);
        end
        crc_byte = acc;
    endfunction : crc_byte

    function automatic logic [5:0] reg_len(input logic [5:0] a, input logic stat_on);
        if (a == aspcc_pkg::ADDR_DATA) begin
            reg_len = stat_on ? aspcc_pkg::LEN_32 : aspcc_pkg::LEN_24;
        end else if (a == aspcc_pkg::ADDR_OFFSET || a == aspcc_pkg::ADDR_GAIN) begin
            reg_len = aspcc_pkg::LEN_24;
        end else if (a == aspcc_pkg::ADDR_ADCMODE || a == aspcc_pkg::ADDR_IFMODE) begin
            reg_len = aspcc_pkg::LEN_16;
        end else begin
            reg_len = aspcc_pkg::LEN_8;
        end
    endfunction : reg_len

    function automatic logic [23:0] sat24(input logic signed [31:0] v);
        if (v < 0) begin
            sat24 = 24'h000000;
        end else if (v > 32'sh00ffffff) begin
            sat24 = 24'hffffff;
        end else begin
            sat24 = v[23:0];
        end
    endfunction : sat24

    // Command byte of continuous read is folded in up front
    localparam logic [7:0] CONT_SEED = crc_byte(8'h00, aspcc_pkg::CMD_CONT_READ);

    logic sel, bit_in, rise, fall;
    assign sel    = ~sync_b_r[1];
    assign bit_in = sync_b_r[0];
    assign rise   = sel & sync_b_r[2] & ~sclk_d_r;
    assign fall   = sel & ~sync_b_r[2] & sclk_d_r;

    logic [2:0] mode;
    logic       cont_mode, chk_on, int_cal;
    assign mode      = adcmode_r.mode;
    assign cont_mode = ifmode_r.cont_read;
    assign chk_on    = ifmode_r.crc_sel != aspcc_pkg::CRC_OFF;
    assign int_cal   = mode == aspcc_pkg::MODE_INT_ZERO || mode == aspcc_pkg::MODE_INT_FULL;
    assign stat      = '{rdy_n: rdy_n_r, adc_err: 1'b0, crc_err: crc_err_r,
                         rsvd: 1'b0, channel: chan_r};

    logic [7:0]  cmd_byte;
    logic [23:0] rx_word;
    logic [31:0] data_word, rd_word;
    assign cmd_byte  = {rx_sr_r[6:0], bit_in};
    assign rx_word   = {rx_sr_r[22:0], bit_in};
    assign data_word = ifmode_r.data_stat ? {data_r, stat} : {data_r, 8'h00};
    assign rd_word   =
        (cmd_byte[5:0] == aspcc_pkg::ADDR_STATUS)  ? {stat, 24'h000000} :
        (cmd_byte[5:0] == aspcc_pkg::ADDR_ADCMODE) ? {adcmode_r, 16'h0000} :
        (cmd_byte[5:0] == aspcc_pkg::ADDR_IFMODE)  ? {ifmode_r, 16'h0000} :
        (cmd_byte[5:0] == aspcc_pkg::ADDR_DATA)    ? data_word :
        (cmd_byte[5:0] == aspcc_pkg::ADDR_OFFSET && !int_cal) ? {offset_r, 8'h00} :
        (cmd_byte[5:0] == aspcc_pkg::ADDR_GAIN && !int_cal)   ? {gain_r, 8'h00} :
        32'h00000000;

    logic in_cmd, in_wr, in_wcrc, in_rd;
    assign in_cmd  = st_r == aspcc_pkg::ST_CMD;
    assign in_wr   = st_r == aspcc_pkg::ST_WR;
    assign in_wcrc = st_r == aspcc_pkg::ST_WCRC;
    assign in_rd   = st_r == aspcc_pkg::ST_RD;

    logic cmd_done, accept_cmd, wr_last, wcrc_last, crc_ok, commit;
    logic rd_last, rd_data_done, stat_rd_done, exit_cont, auto_rd, soft_rst;
    logic [5:0]  rd_total, chk_pos;
    logic [7:0]  chk_byte;
    logic [23:0] commit_data;
    logic        next_out;
    assign cmd_done   = rise & in_cmd & (bit_cnt_r == aspcc_pkg::BYTE_LAST);
    // In continuous read only the dummy data read is recognised
    assign accept_cmd = cmd_done & ~cmd_byte[7] &
                        (~cont_mode | (cmd_byte == aspcc_pkg::CMD_CONT_READ));
    assign wr_last    = rise & in_wr & ((bit_cnt_r + 6'h01) == len_r);
    assign wcrc_last  = rise & in_wcrc & (bit_cnt_r == aspcc_pkg::BYTE_LAST);
    assign crc_ok     = cmd_byte == crc_r;
    assign commit     = (wr_last & ~chk_on) | (wcrc_last & crc_ok);
    assign commit_data = chk_on ? wdata_r : rx_word;
    assign rd_total   = len_r + (chk_on ? aspcc_pkg::LEN_8 : 6'h00);
    assign rd_last    = rise & in_rd & ((bit_cnt_r + 6'h01) == rd_total);
    assign rd_data_done = rd_last & data_rd_r;
    assign stat_rd_done = rd_last & (addr_r == aspcc_pkg::ADDR_STATUS);
    assign exit_cont  = cont_mode & ((accept_cmd) |
                        (rise & in_rd & (bit_cnt_r == aspcc_pkg::BYTE_LAST) &
                         (cmd_byte == aspcc_pkg::CMD_CONT_READ)));
    assign auto_rd    = cont_pend_r & cont_mode & in_cmd & (bit_cnt_r == 6'h00) & ~rise;
    assign soft_rst   = rise & bit_in & (ones_cnt_r == aspcc_pkg::SRST_LAST);
    assign chk_byte   = (ifmode_r.crc_sel == aspcc_pkg::CRC_XOR) ? xacc_r : crc_r;
    assign chk_pos    = bit_cnt_r - len_r;
    assign next_out   = (bit_cnt_r < len_r) ? tx_sr_r[31] : chk_byte[3'h7 - chk_pos[2:0]];

    // Correction path
    logic [16:0]        weight;
    logic signed [40:0] wprod;
    logic signed [24:0] scaled;
    logic signed [26:0] samp_x, off_delta, diff;
    logic signed [51:0] gprod;
    logic signed [29:0] gq;
    logic signed [31:0] uni_v, bip_v, zero_v;
    logic [45:0]        gdiv;
    logic [23:0]        result, offset_cal, gain_cal;
    assign weight    = low_level_input ? aspcc_pkg::W_LOW : aspcc_pkg::W_VOLT;
    assign wprod     = $signed({{17{conv_ratio[23]}}, conv_ratio}) * $signed({24'h000000, weight});
    assign scaled    = 25'(wprod >>> aspcc_pkg::WEIGHT_SHIFT);
    assign samp_x    = $signed({{2{samp_r[24]}}, samp_r});
    assign off_delta = $signed({3'h0, offset_r}) - $signed({3'h0, aspcc_pkg::MID_SCALE});
    assign diff      = samp_x - off_delta;
    assign gprod     = diff * $signed({28'h0000000, gain_r});
    assign gq        = 30'(gprod >>> aspcc_pkg::GAIN_SHIFT);
    assign uni_v     = 32'(gq) <<< 1;
    assign bip_v     = 32'(gq) + $signed({8'h00, aspcc_pkg::MID_SCALE});
    assign result    = sat24(bipolar_coding ? bip_v : uni_v);
    assign zero_v    = $signed({{7{samp_r[24]}}, samp_r}) + $signed({8'h00, aspcc_pkg::MID_SCALE});
    assign offset_cal = sat24(zero_v);
    // Gain that maps the present sample to full scale; nonpositive span keeps old gain
    assign gdiv      = aspcc_pkg::GAIN_NUM / {19'h00000, diff[26:0]};
    assign gain_cal  = (diff <= 0) ? gain_r : ((gdiv[45:24] != 22'h000000) ? 24'hffffff : gdiv[23:0]);

    logic conv_go, is_cal, is_zero;
    assign conv_go = conv_valid & (mode != aspcc_pkg::MODE_STANDBY);
    assign is_cal  = mode[2];
    assign is_zero = mode == aspcc_pkg::MODE_INT_ZERO || mode == aspcc_pkg::MODE_SYS_ZERO;

    aspcc_pkg::aspcc_adcmode_t new_mode;
    assign new_mode = aspcc_pkg::aspcc_adcmode_t'(commit_data[15:0]);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_a_r <= 3'h7;
            sync_b_r <= 3'h7;
            sclk_d_r <= 1'b1;
        end else begin
            sync_a_r <= {sclk, cs_n, din};
            sync_b_r <= sync_a_r;
            sclk_d_r <= sync_b_r[2];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !sel) begin
            ones_cnt_r <= 7'h00;
        end else if (rise) begin
            ones_cnt_r <= (bit_in && !soft_rst) ? ones_cnt_r + 7'h01 : 7'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst || !sel) begin
            st_r      <= aspcc_pkg::ST_CMD;
            bit_cnt_r <= 6'h00;
            len_r     <= aspcc_pkg::LEN_8;
            addr_r    <= 6'h00;
            rx_sr_r   <= 32'h00000000;
            tx_sr_r   <= 32'h00000000;
            wdata_r   <= 24'h000000;
            crc_r     <= 8'h00;
            xacc_r    <= 8'h00;
            data_rd_r <= 1'b0;
        end else if (auto_rd) begin
            st_r      <= aspcc_pkg::ST_RD;
            len_r     <= reg_len(aspcc_pkg::ADDR_DATA, ifmode_r.data_stat);
            addr_r    <= aspcc_pkg::ADDR_DATA;
            tx_sr_r   <= data_word;
            crc_r     <= CONT_SEED;
            xacc_r    <= aspcc_pkg::CMD_CONT_READ;
            data_rd_r <= 1'b1;
        end else if (rise) begin
            rx_sr_r   <= {rx_sr_r[30:0], bit_in};
            bit_cnt_r <= bit_cnt_r + 6'h01;
            case (st_r)
                aspcc_pkg::ST_CMD: begin
                    crc_r <= crc_step(crc_r, bit_in);
                    if (cmd_done) begin
                        bit_cnt_r <= 6'h00;
                        addr_r    <= cmd_byte[5:0];
                        len_r     <= reg_len(cmd_byte[5:0], ifmode_r.data_stat);
                        tx_sr_r   <= rd_word;
                        xacc_r    <= cmd_byte;
                        data_rd_r <= cmd_byte[5:0] == aspcc_pkg::ADDR_DATA;
                        if (!accept_cmd) begin
                            crc_r <= 8'h00;
                        end else begin
                            st_r <= cmd_byte[6] ? aspcc_pkg::ST_RD : aspcc_pkg::ST_WR;
                        end
                    end
                end
                aspcc_pkg::ST_WR: begin
                    crc_r <= crc_step(crc_r, bit_in);
                    if (wr_last) begin
                        bit_cnt_r <= 6'h00;
                        wdata_r   <= rx_word;
                        st_r      <= chk_on ? aspcc_pkg::ST_WCRC : aspcc_pkg::ST_CMD;
                        if (!chk_on) begin
                            crc_r <= 8'h00;
                        end
                    end
                end
                aspcc_pkg::ST_WCRC: begin
                    if (wcrc_last) begin
                        bit_cnt_r <= 6'h00;
                        crc_r     <= 8'h00;
                        st_r      <= aspcc_pkg::ST_CMD;
                    end
                end
                aspcc_pkg::ST_RD: begin
                    if (bit_cnt_r < len_r) begin
                        crc_r  <= crc_step(crc_r, dout);
                        xacc_r <= xacc_r ^ (8'(dout) << (3'h7 - bit_cnt_r[2:0]));
                    end
                    if (rd_last) begin
                        bit_cnt_r <= 6'h00;
                        crc_r     <= 8'h00;
                        st_r      <= aspcc_pkg::ST_CMD;
                    end
                end
                default: begin
                    st_r <= aspcc_pkg::ST_CMD;
                end
            endcase
        end else if (fall && in_rd && bit_cnt_r < len_r) begin
            tx_sr_r <= {tx_sr_r[30:0], 1'b0};
        end
    end

    // Line carries the ready level whenever no read is shifting
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dout    <= 1'b1;
            dout_oe <= 1'b0;
        end else begin
            dout_oe <= sel;
            if (!in_rd) begin
                dout <= rdy_n_r;
            end else if (fall) begin
                dout <= next_out;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst) begin
            adcmode_r   <= aspcc_pkg::ADCMODE_RESET;
            ifmode_r    <= aspcc_pkg::IFMODE_RESET;
            offset_r    <= aspcc_pkg::MID_SCALE;
            gain_r      <= GAIN_RESET;
            data_r      <= 24'h000000;
            chan_r      <= 4'h0;
            rdy_n_r     <= 1'b1;
            crc_err_r   <= 1'b0;
            stage_r     <= 1'b0;
            cont_pend_r <= 1'b0;
            samp_r      <= 25'sh0000000;
            cal_route   <= aspcc_pkg::ROUTE_NORMAL;
            conv_enable <= 1'b0;
        end else begin
            if (commit && addr_r == aspcc_pkg::ADDR_ADCMODE) begin
                adcmode_r <= new_mode;
                if (new_mode.mode[2]) begin
                    rdy_n_r <= 1'b1;
                end
            end
            if (commit && addr_r == aspcc_pkg::ADDR_IFMODE) begin
                ifmode_r <= aspcc_pkg::aspcc_ifmode_t'(commit_data[15:0]);
            end
            if (commit && addr_r == aspcc_pkg::ADDR_OFFSET && !int_cal) begin
                offset_r <= commit_data;
            end
            if (commit && addr_r == aspcc_pkg::ADDR_GAIN && !int_cal) begin
                gain_r <= commit_data;
            end
            if (exit_cont) begin
                ifmode_r.cont_read <= 1'b0;
            end
            if (stat_rd_done) begin
                crc_err_r <= 1'b0;
            end
            if (wcrc_last && !crc_ok) begin
                crc_err_r <= 1'b1;
            end
            if (rd_data_done) begin
                rdy_n_r <= 1'b1;
            end
            if (auto_rd) begin
                cont_pend_r <= 1'b0;
            end
            stage_r <= conv_go;
            if (conv_go) begin
                samp_r  <= scaled;
                chan_r  <= conv_channel;
                rdy_n_r <= 1'b1;
            end
            if (stage_r) begin
                rdy_n_r <= 1'b0;
                if (is_cal) begin
                    adcmode_r.mode <= aspcc_pkg::MODE_STANDBY;
                    if (is_zero) begin
                        offset_r <= offset_cal;
                    end else begin
                        gain_cal_apply: gain_r <= gain_cal;
                    end
                end else begin
                    data_r      <= result;
                    cont_pend_r <= cont_mode;
                    if (mode == aspcc_pkg::MODE_SINGLE) begin
                        adcmode_r.mode <= aspcc_pkg::MODE_STANDBY;
                    end
                end
            end
            cal_route <= (mode == aspcc_pkg::MODE_INT_ZERO) ? aspcc_pkg::ROUTE_SHORT :
                         (mode == aspcc_pkg::MODE_INT_FULL) ? aspcc_pkg::ROUTE_FULL :
                         aspcc_pkg::ROUTE_NORMAL;
            conv_enable <= mode != aspcc_pkg::MODE_STANDBY;
        end
    end
endmodule : aspcc_top
`default_nettype wire

// *** test/aspcc_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module aspcc_top_sva (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               sclk,
    input wire logic               cs_n,
    input wire logic               din,
    input wire logic               dout,
    input wire logic               dout_oe,
    input wire logic               conv_valid,
    input wire logic signed [23:0] conv_ratio,
    input wire logic [3:0]         conv_channel,
    input wire logic               low_level_input,
    input wire logic               bipolar_coding,
    input wire logic [1:0]         cal_route,
    input wire logic               conv_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    rst_values_a: assert property ($past(sys_rst) |-> dout && !dout_oe && cal_route == 2'h0)
        else $error("outputs not at reset values");
    run_after_a: assert property ($past(sys_rst) |=> conv_enable)
        else $error("conversions not running after reset");
    oe_on_a: assert property (!cs_n [*5] |-> dout_oe)
        else $error("data line not driven while selected");
    oe_off_a: assert property (cs_n [*5] |-> !dout_oe)
        else $error("data line driven while deselected");
    route_legal_a: assert property (cal_route != 2'h3)
        else $error("unknown calibration routing");
    cal_runs_a: assert property (cal_route != 2'h0 |-> conv_enable)
        else $error("calibration routed while converter stopped");
    cal_start_a: assert property ($rose(cal_route != 2'h0) |-> ##[0:2] dout)
        else $error("ready not high at calibration start");
    cal_end_a: assert property (conv_valid && cal_route != 2'h0 |->
        ##[1:3] (cal_route == 2'h0 && !conv_enable))
        else $error("calibration did not end in standby");
endmodule : aspcc_top_sva
`default_nettype wire

// *** test/aspcc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module aspcc_host (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic miso
);
    initial begin
        sclk = 1'h1;
        cs_n = 1'h1;
        din  = 1'h0;
    end
    function automatic logic [7:0] crc8(input logic [63:0] m, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = n - 1; i >= 0; i--) begin
            c = {c[6:0], 1'h0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc8
    // Clock parks high between frames; din flips so a stale bit is never mistaken for data
    task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = 64'h0;
        @(negedge clk);
        cs_n = 1'h0;
        repeat (3) @(negedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'h0;
            din  = tx[i];
            repeat (8) @(negedge clk);
            rx   = {rx[62:0], miso};
            sclk = 1'h1;
            repeat (8) @(negedge clk);
        end
        din = ~din;
    endtask : xfer
endmodule : aspcc_host
`default_nettype wire

// *** test/tb_adc_serial_port_calibration_crc.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_port_calibration_crc;
    localparam logic [23:0] GAIN_RESET = 24'h555550;
    logic clk = 1'h0;
    logic sys_rst, conv_valid, low_level_input, bipolar_coding;
    logic signed [23:0] conv_ratio;
    logic [3:0]  conv_channel;
    logic [63:0] v;
    wire logic   sclk, cs_n, din, dout, dout_oe, conv_enable;
    wire logic [1:0] cal_route;
    wire logic   dout_w = dout_oe ? dout : 1'h1;
    int          error_cnt, compares;
    always #5 clk = ~clk;
    aspcc_host host (.clk, .sclk, .cs_n, .din, .miso(dout_w));
    aspcc_top #(.GAIN_RESET(GAIN_RESET)) dut (.clk, .sys_rst, .sclk, .cs_n, .din, .dout,
        .dout_oe, .conv_valid, .conv_ratio, .conv_channel, .low_level_input,
        .bipolar_coding, .cal_route, .conv_enable);
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic rd(input logic [7:0] a, input int n);
        host.xfer(64'(a) << n, n + 8, v);
    endtask : rd
    task automatic conv(input logic signed [23:0] r);
        conv_ratio = r;
        conv_valid = 1'h1;
        @(negedge clk);
        conv_valid = 1'h0;
        repeat (5) @(negedge clk);
    endtask : conv
    function automatic logic [23:0] corr(input bit lo, input bit bip);
        longint q;
        q = ((longint'(24'sh100000) * (lo ? 49152 : 4915)) >>> 16) * longint'(GAIN_RESET) >>> 22;
        q = bip ? q + 64'sh800000 : q * 2;
        return (q > 64'shffffff) ? 24'hffffff : q[23:0];
    endfunction : corr
    task automatic t_reset_vals();
        chk("oe idle", dout_oe, 1'h0);
        rd(8'h70, 24);
        chk("offset", v[23:0], 24'h800000);
        rd(8'h78, 24);
        chk("gain", v[23:0], GAIN_RESET);
    endtask : t_reset_vals
    task automatic t_conversions();
        for (int i = 0; i < 4; i++) begin
            low_level_input = i[0];
            bipolar_coding  = i[1];
            conv(24'sh100000);
            chk("ready low", dout_w, 1'h0);
            rd(8'h44, 24);
            chk("data", v[23:0], corr(i[0], i[1]));
            repeat (4) @(negedge clk);
            chk("ready high", dout_w, 1'h1);
            rd(8'h44, 24);
            chk("reread", v[23:0], corr(i[0], i[1]));
        end
    endtask : t_conversions
    task automatic t_calib();
        // Internal zero, internal full, system zero, system full; one channel only
        for (int m = 4; m < 8; m++) begin
            host.xfer(64'h010000 | 64'(m << 4), 24, v);
            repeat (4) @(negedge clk);
            chk("route", cal_route, (m == 4) ? 2'h1 : (m == 5) ? 2'h2 : 2'h0);
            chk("cal busy", dout_w, 1'h1);
            if (m == 4) rd(8'h70, 24);
            if (m == 4) chk("locked", v[23:0], 24'h0);
            conv(m[0] ? 24'sh400000 : 24'sh010000);
            chk("standby", conv_enable, 1'h0);
            chk("cal done", dout_w, 1'h0);
            if (m == 4) rd(8'h70, 24);
            if (m == 4) chk("offset cal", v[23:0], 24'h80c000);
            // Span 0x2f4000 above the new offset gives gain 2^45 / span
            if (m == 5) rd(8'h78, 24);
            if (m == 5) chk("gain cal", v[23:0], 24'had602b);
        end
    endtask : t_calib
    task automatic t_serial_reset();
        host.xfer(64'hffffffffffffffff, 64, v);
        repeat (50000) @(negedge clk);
        rd(8'h70, 24);
        chk("offset restored", v[23:0], 24'h800000);
        chk("mode restored", conv_enable, 1'h1);
    endtask : t_serial_reset
    task automatic t_checksum();
        host.xfer(64'h020008, 24, v);
        rd(8'h40, 16);
        chk("status crc", v[7:0], host.crc8({8'h40, v[15:8]}, 16));
        host.xfer({8'h30, 24'h123456, host.crc8(64'h30123456, 32) ^ 8'h01}, 40, v);
        rd(8'h40, 16);
        chk("crc flag", v[13], 1'h1);
        rd(8'h70, 32);
        chk("offset kept", v[31:8], 24'h800000);
        host.xfer({8'h02, 16'h0004, host.crc8(64'h020004, 24)}, 32, v);
        rd(8'h78, 32);
        chk("gain", v[31:8], GAIN_RESET);
        chk("xor crc", v[7:0], 8'h78 ^ v[31:24] ^ v[23:16] ^ v[15:8]);
    endtask : t_checksum
    task automatic t_cont_read();
        // Continuous read, status append, polynomial checksum on reads
        host.xfer({8'h02, 16'h00c8, host.crc8(64'h0200c8, 24)}, 32, v);
        conv(24'sh100000);
        chk("cont ready", dout_w, 1'h0);
        host.xfer(64'h0, 40, v);
        chk("cont data", v[39:16], corr(1'h1, 1'h1));
        chk("cont status", v[15:8], 8'h03);
        chk("cont crc", v[7:0], host.crc8({8'h44, v[39:8]}, 40));
        host.xfer(64'h0, 40, v);
        chk("read once", v[39:0], 64'h000000ffffffffff);
    endtask : t_cont_read
    initial begin
        sys_rst         = 1'h1;
        conv_valid      = 1'h0;
        conv_ratio      = 24'sh0;
        conv_channel    = 4'h3;
        low_level_input = 1'h0;
        bipolar_coding  = 1'h0;
        repeat (5) @(negedge clk);
        sys_rst = 1'h0;
        repeat (4) @(negedge clk);
        t_reset_vals();
        t_conversions();
        t_calib();
        t_serial_reset();
        t_checksum();
        t_cont_read();
        give_verdict();
    end
    initial begin
        #1000000;
        error_cnt++;
        give_verdict();
    end
endmodule : tb_adc_serial_port_calibration_crc
bind aspcc_top aspcc_top_sva chk_i (.clk, .sys_rst, .sclk, .cs_n, .din, .dout, .dout_oe,
    .conv_valid, .conv_ratio, .conv_channel, .low_level_input, .bipolar_coding,
    .cal_route, .conv_enable);
`default_nettype wire
